/* dv/peer_link_model.sv */
module peer_link_model
    import link_retry_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Flit stream from the link
    input wire logic tx_valid_i,
    input wire logic [2:0] tx_kind_i,
    input wire logic [1:0] flags_i,
    input wire logic [PTR_W-1:0] ptr_i,
    input wire logic [SEQ_W-1:0] seq_i,
    input wire logic save_i,
    input wire logic redo_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic tail_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Stream record: {saved, flags, pointer, length}
    logic [18:0] streams[$];
    // Flit record: {tail, data, save, redo, kind, pointer, sequence}
    logic [48:0] flits[$];
    int len = 0;
    logic [1:0] fl = 2'h0;
    logic [7:0] lp = 8'h00;
    logic sv = 1'b0;

    // A null or other flit closes a retry stream, so a gap splits it
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            len = 0;
        end else if (tx_valid_i && tx_kind_i == kind_retry &&
                (len == 0 || flags_i == fl)) begin
            len++;
            fl = flags_i;
            lp = ptr_i;
            sv = sv | save_i;
        end else begin
            if (len > 0) streams.push_back({sv, fl, lp, len[7:0]});
            len = 0;
            sv = 1'b0;
            if (tx_valid_i) begin
                flits.push_back({tail_i, data_i, save_i, redo_i,
                    tx_kind_i, ptr_i, seq_i});
            end
        end
    end
endmodule // peer_link_model

/* dv/tb_top.sv */
module tb_top;
    import link_retry_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0;
    logic avs_write_i = 1'b0, abort_i = 1'b0, replay_req_i = 1'b0;
    logic fwd_ptr_valid_i = 1'b0, ret_ptr_valid_i = 1'b0;
    logic src_valid_i = 1'b0, src_tail_i = 1'b1, saved_pending_i = 1'b0;
    logic rsnd_valid_i = 1'b0, rsnd_tail_i = 1'b1, rsnd_last_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h0, src_data_i = 32'h0;
    logic [31:0] rsnd_data_i = 32'h0, q, dv, seed = 32'h7211;
    logic [PTR_W-1:0] fwd_ptr_i = 8'h00, ret_ptr_i = 8'h00, cur = 8'h00;
    logic [SEQ_W-1:0] rsnd_seq_i = 3'h0, rseq[3];
    logic [31:0] avs_readdata_o, tx_data_o;
    logic avs_waitrequest_o, src_ready_o, rsnd_ready_o, rd_ptr_load_o;
    logic tx_valid_o, tx_tail_o, tx_save_o, tx_crc_redo_o;
    logic link_retry_failed_o;
    logic [PTR_W-1:0] rd_ptr_o, tx_return_ptr_o;
    logic [2:0] tx_kind_o;
    logic [1:0] tx_ctrl_flags_o;
    logic [SEQ_W-1:0] tx_seq_o;
    logic [18:0] s;
    logic [48:0] f;
    int failures = 0, checks = 0, cyc = 0, ri = 0, sq = 0;

    link_master_retry_control u_link_master_retry_control (
        .clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .abort_i, .replay_req_i, .fwd_ptr_valid_i,
        .fwd_ptr_i, .ret_ptr_valid_i, .ret_ptr_i, .src_valid_i, .src_data_i,
        .src_tail_i, .src_ready_o, .saved_pending_i, .rsnd_valid_i,
        .rsnd_data_i, .rsnd_seq_i, .rsnd_tail_i, .rsnd_last_i, .rsnd_ready_o,
        .rd_ptr_load_o, .rd_ptr_o, .tx_valid_o, .tx_kind_o, .tx_data_o,
        .tx_tail_o, .tx_ctrl_flags_o, .tx_return_ptr_o, .tx_seq_o,
        .tx_save_o, .tx_crc_redo_o, .link_retry_failed_o);

    peer_link_model u_peer_link_model (.clk_i(clk_sys_i), .nrst_i,
        .tx_valid_i(tx_valid_o), .tx_kind_i(tx_kind_o),
        .flags_i(tx_ctrl_flags_o), .ptr_i(tx_return_ptr_o),
        .seq_i(tx_seq_o), .save_i(tx_save_o), .redo_i(tx_crc_redo_o),
        .data_i(tx_data_o), .tail_i(tx_tail_o));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // Saved-packet source; index moves on each accepted flit
    always @(posedge clk_sys_i) begin
        if (rsnd_valid_i && rsnd_ready_o) ri = ri + 1;
        rsnd_valid_i <= saved_pending_i && ri < 3;
        rsnd_data_i <= rnd();
        rsnd_seq_i <= rseq[ri%3];
        rsnd_last_i <= ri == 2;
    end

    task chk(input string n, input logic [31:0] v, input logic [31:0] e);
        checks++;
        if (v !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        // Sampled at the rising edge; only the bench timeout ends the wait
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge clk_sys_i);
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task get_s();
        int n;
        n = 0;
        while (u_peer_link_model.streams.size() == 0 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        s = (n < 200) ? u_peer_link_model.streams.pop_front() : '1;
    endtask

    task get_f();
        int n;
        n = 0;
        while (u_peer_link_model.flits.size() == 0 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        f = (n < 200) ? u_peer_link_model.flits.pop_front() : '1;
    endtask

    task pulse(input logic ret, input logic [7:0] v);
        @(posedge clk_sys_i);
        ret_ptr_valid_i <= ret;
        fwd_ptr_valid_i <= !ret;
        ret_ptr_i <= v;
        fwd_ptr_i <= v;
        @(posedge clk_sys_i);
        ret_ptr_valid_i <= 1'b0;
        fwd_ptr_valid_i <= 1'b0;
    endtask

    task ack(input logic [7:0] v);
        int n;
        n = 0;
        pulse(1'b1, v);
        while (rd_ptr_load_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("rd_load", rd_ptr_load_o, 1'b1);
        chk("rd_ptr", rd_ptr_o, v);
    endtask

    task send();
        int n;
        n = 0;
        @(posedge clk_sys_i);
        dv = rnd();
        src_valid_i <= 1'b1;
        src_data_i <= dv;
        @(negedge clk_sys_i);
        while (src_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(posedge clk_sys_i);
        src_valid_i <= 1'b0;
        sq++;
        get_f();
        chk("normal", f[15:0], {2'b10, kind_normal, cur, sq[2:0]});
        chk("data", f[47:16], dv);
        chk("tail", f[48], 1'b1);
    endtask

    task stream(input logic [1:0] fl);
        get_s();
        chk("stream", s, {1'b0, fl, cur, 8'h03});
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", q, 32'h308);
        bus(1'b0, REG_TIMEOUT, 32'h0);
        chk("timeout", q, TIMEOUT_RESET);
        bus(1'b0, 4'h1, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b1, REG_CTRL, 32'h303);
        // Short timeout keeps the run brief; bench has no buffer-full delay
        bus(1'b1, REG_TIMEOUT, 32'd20);
        send();
        cur = PTR_W'(rnd());
        pulse(1'b0, cur);
        get_f();
        chk("pointer_return_packet", f[15:3], {2'b00, kind_pointer_return_packet, cur});
        ack(PTR_W'(rnd()));
        @(posedge clk_sys_i);
        abort_i <= 1'b1;
        repeat (4) stream(FLAG_REPORT);
        repeat (100) @(posedge clk_sys_i);
        chk("extra", u_peer_link_model.streams.size(), 0);
        chk("failed", link_retry_failed_o, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("status", q & 32'h1FF, 32'h00F);
        abort_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("cleared", q & 32'h1FF, 32'h002);
        bus(1'b1, REG_STATUS, 32'h2);
        @(negedge clk_sys_i);
        chk("failed", link_retry_failed_o, 1'b0);
        send();
        pulse(1'b0, 8'h00);
        replay_req_i <= 1'b1;
        @(posedge clk_sys_i);
        replay_req_i <= 1'b0;
        cur = 8'h00;
        get_f();
        chk("pointer_return_packet", f[15:3], {2'b00, kind_pointer_return_packet, cur});
        stream(FLAG_REPLAY);
        send();
        foreach (rseq[k]) rseq[k] = SEQ_W'(rnd());
        @(posedge clk_sys_i);
        saved_pending_i <= 1'b1;
        replay_req_i <= 1'b1;
        @(posedge clk_sys_i);
        replay_req_i <= 1'b0;
        ack(PTR_W'(rnd()));
        stream(FLAG_REPLAY);
        for (int k = 0; k < 3; k++) begin
            get_f();
            chk("resend", f[14:0], {1'b1, kind_resend, cur, rseq[k]});
        end
        @(posedge clk_sys_i);
        saved_pending_i <= 1'b0;
        send();
        report_and_stop();
    end
endmodule // tb_top

/* include/link_retry_pkg.sv */
package link_retry_pkg;

    localparam int PTR_W = 8;
    localparam int SEQ_W = 3;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    localparam int ATT_W = 4;
    localparam int TMR_W = 32;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TIMEOUT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_POINTER = 4'hC;

    // Control register fields
    localparam int CTRL_TXNUM_LSB = 0;
    localparam int CTRL_LIMIT_LSB = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0FFF;
    localparam logic [CNT_W-1:0] TXNUM_RESET = 8'h08;
    localparam logic [ATT_W-1:0] LIMIT_RESET = 4'h3;
    localparam logic [TMR_W-1:0] TIMEOUT_RESET = 32'h0000_1000;

    // Status register fields
    localparam int STAT_ABORT_BIT = 0;
    localparam int STAT_FAILED_BIT = 1;
    localparam int STAT_ATT_LSB = 2;
    localparam int STAT_STATE_LSB = 6;
    localparam int STAT_PEND_BIT = 9;

    localparam logic [1:0] FLAG_REPORT = 2'h1;
    localparam logic [1:0] FLAG_REPLAY = 2'h2;

    typedef enum logic [2:0] {
        normal_state = 3'b000,
        report_drain_state = 3'b001,
        report_stream_state = 3'b010,
        replay_drain_state = 3'b011,
        replay_stream_state = 3'b100,
        replay_resend_state = 3'b101
    } retry_state_t;

    typedef enum logic [2:0] {
        kind_null = 3'b000,
        kind_normal = 3'b001,
        kind_pointer_return_packet = 3'b010,
        kind_retry = 3'b011,
        kind_resend = 3'b100
    } flit_kind_t;

endpackage

/* verilog/link_master_retry_control.sv */
// Behaviour
// - Newest forward pointer replaces any pending one.
// - Idle link: send unsaved pointer-return packet.
// - Last pointer reused; one return suffices.
// - Every non-null flit carries collected pointer.
// - Resent flits get newest pointer, CRC redone.
// - Received return pointer acknowledges sent packet.
// - Detector side reports; failing sender replays.
// - Abort rise or expiry: drain, then report.
// - Report stream: configured count, flag bit 0.
// - Retry streams are contiguous, no null flits.
// - Retry packets never saved, fields meaningless.
// - After report stream resume queued normal flow.
// - Abort clear holds timer, attempts, expiry zero.
// - Timer counts; timeout pulses expiry, retries again.
// - Attempts at limit: stop, flag retry failed.
// - Replay request: drain in-flight packet, enter replay.
// - Replay stream: configured count, flag bit 1.
// - Resend all saved packets, skip if none.
// - Abort during resend: finish resend, then report.
// - Replay ends after stream or resend; resume.
// - Return field is zero before first pointer.
// - Resent packets keep original sequence numbers.
// - Replay-time return pointers held, loaded after.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
module link_master_retry_control
    import link_retry_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Register bus
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Local receive section
    input wire logic abort_i,
    input wire logic replay_req_i,
    input wire logic fwd_ptr_valid_i,
    input wire logic [PTR_W-1:0] fwd_ptr_i,
    input wire logic ret_ptr_valid_i,
    input wire logic [PTR_W-1:0] ret_ptr_i,
    // Normal packet source
    input wire logic src_valid_i,
    input wire logic [DATA_W-1:0] src_data_i,
    input wire logic src_tail_i,
    output logic src_ready_o,
    // Saved packet source
    input wire logic saved_pending_i,
    input wire logic rsnd_valid_i,
    input wire logic [DATA_W-1:0] rsnd_data_i,
    input wire logic [SEQ_W-1:0] rsnd_seq_i,
    input wire logic rsnd_tail_i,
    input wire logic rsnd_last_i,
    output logic rsnd_ready_o,
    // Buffer read pointer
    output logic rd_ptr_load_o,
    output logic [PTR_W-1:0] rd_ptr_o,
    // Outgoing flit
    output logic tx_valid_o,
    output logic [2:0] tx_kind_o,
    output logic [DATA_W-1:0] tx_data_o,
    output logic tx_tail_o,
    output logic [1:0] tx_ctrl_flags_o,
    output logic [PTR_W-1:0] tx_return_ptr_o,
    output logic [SEQ_W-1:0] tx_seq_o,
    output logic tx_save_o,
    output logic tx_crc_redo_o,
    // Status
    output logic link_retry_failed_o
);

    logic [31:0] be_mask;
    logic bus_ack, next_bus_ack;
    logic [31:0] readdata, next_readdata;
    logic [31:0] ctrl, next_ctrl;
    logic [TMR_W-1:0] timeout, next_timeout;
    logic [CNT_W-1:0] tx_num;
    logic [ATT_W-1:0] limit;
    logic bus_req, bus_wr;

    logic abort_q;
    logic [TMR_W-1:0] timer, next_timer;
    logic [ATT_W-1:0] attempts, next_attempts;
    logic expired, next_expired;
    logic failed, next_failed;
    logic report_trig;

    retry_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic in_pkt, next_in_pkt;
    logic [SEQ_W-1:0] seq, next_seq;
    logic report_req, next_report_req;
    logic replay_req, next_replay_req;
    logic [PTR_W-1:0] cur_ptr, next_cur_ptr;
    logic ptr_pend, next_ptr_pend;
    logic [PTR_W-1:0] hold_ptr, next_hold_ptr;
    logic hold_valid, next_hold_valid;
    logic next_rd_load;
    logic [PTR_W-1:0] next_rd_ptr;
    logic send_normal, in_replay;

    flit_kind_t next_kind;
    logic [DATA_W-1:0] next_data;
    logic next_tail;
    logic [1:0] next_flags;
    logic [SEQ_W-1:0] next_tx_seq;
    logic next_save, next_redo;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_be
            assign be_mask[8*g +: 8] = {8{avs_byteenable_i[g]}};
        end
    endgenerate

    // Register bus: every access waits exactly one cycle
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_wr = avs_write_i & bus_ack;
    assign avs_waitrequest_o = bus_req & ~bus_ack;
    assign avs_readdata_o = readdata;
    assign tx_num = ctrl[CTRL_TXNUM_LSB +: CNT_W];
    assign limit = ctrl[CTRL_LIMIT_LSB +: ATT_W];
    assign link_retry_failed_o = failed;

    always_comb begin
        next_bus_ack = bus_req & ~bus_ack;
        next_readdata = readdata;
        next_ctrl = ctrl;
        next_timeout = timeout;
        if (avs_read_i && !bus_ack) begin
            unique case (avs_address_i)
                REG_CTRL: next_readdata = ctrl;
                REG_TIMEOUT: next_readdata = timeout;
                REG_STATUS: begin
                    next_readdata = 32'h0000_0000;
                    next_readdata[STAT_ABORT_BIT] = abort_i;
                    next_readdata[STAT_FAILED_BIT] = failed;
                    next_readdata[STAT_ATT_LSB +: ATT_W] = attempts;
                    next_readdata[STAT_STATE_LSB +: 3] = state;
                    next_readdata[STAT_PEND_BIT] = ptr_pend;
                end
                REG_POINTER: next_readdata = {{(32-PTR_W){1'b0}}, cur_ptr};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
        if (bus_wr && avs_address_i == REG_CTRL) begin
            next_ctrl = ((ctrl & ~be_mask) | (avs_writedata_i & be_mask))
                & CTRL_MASK;
        end
        if (bus_wr && avs_address_i == REG_TIMEOUT) begin
            next_timeout = (timeout & ~be_mask) | (avs_writedata_i & be_mask);
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_ack <= 1'b0;
            readdata <= 32'h0000_0000;
            ctrl <= {20'h00000, LIMIT_RESET, TXNUM_RESET};
            timeout <= TIMEOUT_RESET;
        end else begin
            bus_ack <= next_bus_ack;
            readdata <= next_readdata;
            ctrl <= next_ctrl;
            timeout <= next_timeout;
        end
    end

    // Retry timer; a new report starts on abort rise or expiry
    assign report_trig = (abort_i & ~abort_q) | expired;

    always_comb begin
        next_timer = timer;
        next_attempts = attempts;
        next_expired = 1'b0;
        next_failed = failed;
        if (!abort_i) begin
            next_timer = '0;
            next_attempts = '0;
        end else if (timer == timeout && attempts < limit) begin
            next_expired = 1'b1;
            next_attempts = attempts + 1'b1;
            next_timer = '0;
        end else if (attempts == limit) begin
            next_failed = 1'b1;
        end else begin
            next_timer = timer + 1'b1;
        end
        // Write one to clear; a fresh failure wins over the clear
        if (bus_wr && avs_address_i == REG_STATUS
            && avs_byteenable_i[0] && avs_writedata_i[STAT_FAILED_BIT]
            && next_failed == failed) begin
            next_failed = 1'b0;
        end
        if (abort_i && attempts == limit) begin
            next_failed = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            abort_q <= 1'b0;
            timer <= '0;
            attempts <= '0;
            expired <= 1'b0;
            failed <= 1'b0;
        end else begin
            abort_q <= abort_i;
            timer <= next_timer;
            attempts <= next_attempts;
            expired <= next_expired;
            failed <= next_failed;
        end
    end

    // Sequencer and flit selection
    assign in_replay = state == replay_drain_state
        || state == replay_stream_state || state == replay_resend_state;
    assign src_ready_o = state == normal_state
        || ((state == report_drain_state || state == replay_drain_state)
            && in_pkt);
    assign send_normal = src_valid_i & src_ready_o;
    assign rsnd_ready_o = state == replay_resend_state;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_in_pkt = in_pkt;
        next_seq = seq;
        next_report_req = report_req | report_trig;
        next_replay_req = replay_req | replay_req_i;
        next_kind = kind_null;
        next_data = '0;
        next_tail = 1'b0;
        next_flags = 2'h0;
        next_tx_seq = '0;
        next_save = 1'b0;
        next_redo = 1'b0;
        if (send_normal) begin
            next_kind = kind_normal;
            next_data = src_data_i;
            next_tail = src_tail_i;
            next_save = 1'b1;
            next_in_pkt = ~src_tail_i;
            next_tx_seq = seq + 1'b1;
            if (src_tail_i) begin
                next_seq = seq + 1'b1;
            end
        end
        unique case (state)
            normal_state: begin
                if (report_req || report_trig) begin
                    next_state = report_drain_state;
                    next_report_req = 1'b0;
                end else if (replay_req || replay_req_i) begin
                    next_state = replay_drain_state;
                    next_replay_req = 1'b0;
                end
                if (!send_normal && !in_pkt && ptr_pend) begin
                    next_kind = kind_pointer_return_packet;
                    next_tail = 1'b1;
                end
            end
            report_drain_state, replay_drain_state: begin
                next_cnt = '0;
                if (!in_pkt || (send_normal && src_tail_i)) begin
                    if (tx_num == '0) begin
                        next_state = state == report_drain_state
                            ? normal_state : replay_stream_state;
                    end else begin
                        next_state = state == report_drain_state
                            ? report_stream_state : replay_stream_state;
                    end
                end
            end
            report_stream_state: begin
                next_kind = kind_retry;
                next_tail = 1'b1;
                next_flags = FLAG_REPORT;
                next_cnt = cnt + 1'b1;
                if (next_cnt >= tx_num) begin
                    next_state = normal_state;
                end
            end
            replay_stream_state: begin
                if (tx_num != '0) begin
                    next_kind = kind_retry;
                    next_tail = 1'b1;
                    next_flags = FLAG_REPLAY;
                end
                next_cnt = cnt + 1'b1;
                if (next_cnt >= tx_num) begin
                    next_state = saved_pending_i
                        ? replay_resend_state : normal_state;
                end
            end
            replay_resend_state: begin
                if (rsnd_valid_i) begin
                    next_kind = kind_resend;
                    next_data = rsnd_data_i;
                    next_tail = rsnd_tail_i;
                    next_tx_seq = rsnd_seq_i;
                    next_redo = 1'b1;
                    if (rsnd_last_i) begin
                        // Abort seen here waits in report_req
                        next_state = normal_state;
                    end
                end
            end
            default: next_state = normal_state;
        endcase
    end

    // Pointer collection; a pointer arriving while one is sent stays pending
    always_comb begin
        next_cur_ptr = fwd_ptr_valid_i ? fwd_ptr_i : cur_ptr;
        next_ptr_pend = (ptr_pend & ~(next_kind != kind_null && next_tail))
            | fwd_ptr_valid_i;
        next_hold_ptr = hold_ptr;
        next_hold_valid = hold_valid;
        next_rd_load = 1'b0;
        next_rd_ptr = rd_ptr_o;
        if (in_replay) begin
            if (ret_ptr_valid_i) begin
                next_hold_ptr = ret_ptr_i;
                next_hold_valid = 1'b1;
            end
            if (next_state == normal_state) begin
                next_rd_load = next_hold_valid;
                next_rd_ptr = next_hold_ptr;
                next_hold_valid = 1'b0;
            end
        end else if (ret_ptr_valid_i) begin
            next_rd_load = 1'b1;
            next_rd_ptr = ret_ptr_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= normal_state;
            cnt <= '0;
            in_pkt <= 1'b0;
            seq <= '0;
            report_req <= 1'b0;
            replay_req <= 1'b0;
            cur_ptr <= '0;
            ptr_pend <= 1'b0;
            hold_ptr <= '0;
            hold_valid <= 1'b0;
            rd_ptr_load_o <= 1'b0;
            rd_ptr_o <= '0;
            tx_valid_o <= 1'b0;
            tx_kind_o <= kind_null;
            tx_data_o <= '0;
            tx_tail_o <= 1'b0;
            tx_ctrl_flags_o <= 2'h0;
            tx_return_ptr_o <= '0;
            tx_seq_o <= '0;
            tx_save_o <= 1'b0;
            tx_crc_redo_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            in_pkt <= next_in_pkt;
            seq <= next_seq;
            report_req <= next_report_req;
            replay_req <= next_replay_req;
            cur_ptr <= next_cur_ptr;
            ptr_pend <= next_ptr_pend;
            hold_ptr <= next_hold_ptr;
            hold_valid <= next_hold_valid;
            rd_ptr_load_o <= next_rd_load;
            rd_ptr_o <= next_rd_ptr;
            tx_valid_o <= next_kind != kind_null;
            tx_kind_o <= next_kind;
            tx_data_o <= next_data;
            tx_tail_o <= next_tail;
            tx_ctrl_flags_o <= next_flags;
            tx_return_ptr_o <= next_kind == kind_null ? '0 : cur_ptr;
            tx_seq_o <= next_tx_seq;
            tx_save_o <= next_save;
            tx_crc_redo_o <= next_redo;
        end
    end

    // Checks
    ptr_newest_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        fwd_ptr_valid_i |=> cur_ptr == $past(fwd_ptr_i))
        else $error("pointer not replaced by newest");
    pointer_return_packet_idle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == normal_state && !send_normal && !in_pkt && ptr_pend)
        |=> tx_kind_o == kind_pointer_return_packet && !tx_save_o
            && tx_return_ptr_o == $past(cur_ptr))
        else $error("pointer return packet missing");
    return_field_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_valid_o |-> tx_return_ptr_o == $past(cur_ptr))
        else $error("return field not current pointer");
    retry_unsaved_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_kind_o == kind_retry |-> !tx_save_o && tx_seq_o == '0)
        else $error("retry packet marked saved");
    report_stream_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state == report_stream_state |=> tx_kind_o == kind_retry
            && tx_ctrl_flags_o == FLAG_REPORT)
        else $error("report stream flit wrong");
    timer_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !abort_i |=> timer == '0 && attempts == '0 && !expired)
        else $error("timer not cleared");
    limit_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (abort_i && attempts == limit) |=> !expired ##0 failed)
        else $error("retry past limit");
    resend_seq_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == replay_resend_state && rsnd_valid_i)
        |=> tx_seq_o == $past(rsnd_seq_i) && tx_crc_redo_o)
        else $error("resent flit sequence changed");
    replay_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (in_replay && next_state != normal_state) |=> !rd_ptr_load_o)
        else $error("read pointer moved during replay");
    report_entry_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == normal_state && abort_i && !abort_q)
        |=> state == report_drain_state)
        else $error("abort rise did not start report");

    report_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state == report_stream_state ##1 state == normal_state);
    resend_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state == replay_resend_state ##1 state == normal_state);
    pointer_return_packet_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_kind_o == kind_pointer_return_packet);
    expiry_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        expired);

endmodule // link_master_retry_control
